/* sim/fepc_cpu_model.sv */
// CPU model: spaced flash command writes and paired toggle reads
`timescale 1ns/100ps
module fepc_cpu_model (
    input  wire logic       aclk,
    output logic            fl_wr,
    output logic            fl_rd,
    output logic [15:0]     fl_addr,
    output logic [7:0]      fl_wdata,
    input  wire logic [7:0] fl_rdata,
    input  wire logic       fl_rvalid
);
    import fepc_pkg::*;
    logic rv_bad = 1'b0;
    // Bus starts idle; between transfers it carries inverted values
    initial begin
        fl_wr = 1'b0;
        fl_rd = 1'b0;
        fl_addr = 16'h0000;
        fl_wdata = 8'h00;
    end
    // One write pulse, then two idle cycles
    task bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge aclk);
        fl_wr <= 1'b1;
        fl_addr <= a;
        fl_wdata <= d;
        @(posedge aclk);
        fl_wr <= 1'b0;
        fl_addr <= ~a;
        fl_wdata <= ~d;
        repeat (2) @(posedge aclk);
    endtask : bus_wr
    // No interrupt source exists in this model
    task cmd(input logic prog, input logic [15:0] a, input logic [7:0] d);
        bus_wr(UNLOCK_A1, UNLOCK_D1);
        bus_wr(UNLOCK_A2, UNLOCK_D2);
        if (prog) begin
            bus_wr(UNLOCK_A1, CMD_PROG);
            bus_wr(a, d);
        end else begin
            bus_wr(UNLOCK_A1, CMD_ERASE);
            bus_wr(UNLOCK_A1, UNLOCK_D1);
            bus_wr(UNLOCK_A2, UNLOCK_D2);
            bus_wr(a, CMD_SECTOR);
        end
        @(posedge aclk);
    endtask : cmd
    // Read data is registered, so it is taken two edges after the request
    task rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge aclk);
        fl_rd <= 1'b1;
        fl_addr <= a;
        @(posedge aclk);
        fl_rd <= 1'b0;
        fl_addr <= ~a;
        @(posedge aclk);
        v = fl_rdata;
        // Read data must come with its valid strobe
        if (fl_rvalid !== 1'b1) rv_bad = 1'b1;
    endtask : rd
    // Paired reads until they agree; tog tells if the first pair differed
    task poll(input logic [15:0] a, output logic tog, output logic ok,
              output logic [7:0] v);
        logic [7:0] v2;
        ok = 1'b0;
        tog = 1'b0;
        for (int k = 0; k < 40 && !ok; k++) begin
            rd(a, v);
            rd(a, v2);
            if (k == 0) tog = (v !== v2);
            ok = (v === v2);
        end
    endtask : poll
endmodule : fepc_cpu_model

/* sim/fepc_flash_ctrl_tb.sv */
// Testbench: registers, commits, command sequences and toggle polling
`timescale 1ns/100ps
module fepc_flash_ctrl_tb;
    import fepc_pkg::*;
    typedef struct packed {
        logic [7:0] a; logic [31:0] wd; logic [31:0] rd; logic [1:0] rs;
    } fepc_row_t;
    logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, fl_wr, fl_rd;
    logic        fl_rvalid, arr_erase, arr_prog, array_bank_choice, tog, ok;
    logic        ram_code_map, vectors_in_ram, sys_clk_reset, vec_unsafe;
    logic [7:0]  awaddr, araddr, fl_wdata, fl_rdata, arr_rdata, arr_wdata, v;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, flash_window_select;
    logic [15:0] fl_addr, arr_addr;
    int          n_mismatch = 0, n_compared = 0;
    int          n_prog = 0, n_erase = 0, n_rst = 0;
    fepc_row_t   rows [3];
    // Short array times keep polling loops brief
    fepc_flash_ctrl #(.ERASE_CYCLES(40), .PROG_CYCLES(20)) i_dut (
        .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .fl_wr, .fl_rd, .fl_addr,
        .fl_wdata, .fl_rdata, .fl_rvalid, .arr_rdata, .arr_erase, .arr_prog,
        .arr_addr, .arr_wdata, .flash_window_select, .array_bank_choice,
        .ram_code_map, .vectors_in_ram, .sys_clk_reset, .vec_unsafe);
    fepc_cpu_model i_cpu (.aclk, .fl_wr, .fl_rd, .fl_addr, .fl_wdata,
        .fl_rdata, .fl_rvalid);
    assign arr_rdata = fl_addr[7:0] ^ 8'h3c;
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // Pulse counters for array commands and clock reset
    always @(posedge aclk) begin
        if (arr_prog === 1'b1) n_prog++;
        if (arr_erase === 1'b1) n_erase++;
        if (sys_clk_reset === 1'b1) n_rst++;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task complete_run;
        if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    task axi_wr(input logic [7:0] a, input logic [31:0] d,
                input logic [1:0] rs);
        int k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 50 && bvalid !== 1'b1; k++) begin
            @(posedge aclk);
            if (awready === 1'b1) begin
                awvalid <= 1'b0;
                wvalid <= 1'b0;
            end
        end
        if (k == 50) begin
            chk("write timeout", 0, 1);
            complete_run;
        end else begin
            chk("bresp", {30'h0, rs}, {30'h0, bresp});
            bready <= 1'b0;
        end
    endtask : axi_wr
    task axi_rd(input logic [7:0] a, input logic [31:0] e,
                input logic [1:0] rs);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 50 && rvalid !== 1'b1; k++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        if (k == 50) begin
            chk("read timeout", 0, 1);
            complete_run;
        end else begin
            chk("rdata", e, rdata);
            chk("rresp", {30'h0, rs}, {30'h0, rresp});
            rready <= 1'b0;
        end
    endtask : axi_rd
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        ce = 1'b1;
        wstrb = 4'hf;
        rows[0] = '{OFS_MODE, 32'hffff_ffac, 32'h0000_00ac, RESP_OKAY};
        rows[1] = '{OFS_MAP, 32'h0000_0106, 32'h0000_0006, RESP_OKAY};
        rows[2] = '{8'h18, 32'h0000_005a, 32'h0, RESP_SLVERR};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(OFS_MODE, {24'h0, MODE_RST}, RESP_OKAY);
        axi_rd(OFS_STATUS, 32'h0, RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            axi_wr(rows[i].a, rows[i].wd, rows[i].rs);
            axi_rd(rows[i].a, rows[i].rd, rows[i].rs);
        end
        // Mode written but not committed: sequence must be ignored
        i_cpu.cmd(1'b1, 16'he500, 8'h3f);
        chk("prog while off", 0, n_prog);
        axi_wr(OFS_COMMIT, {24'h0, KEY_MAP}, RESP_OKAY);
        chk("window bad key", 0, {30'h0, flash_window_select});
        axi_wr(OFS_COMMIT, {24'h0, KEY_MODE}, RESP_OKAY);
        chk("window", 1, {30'h0, flash_window_select});
        chk("bank", 1, array_bank_choice);
        axi_rd(OFS_STATUS, 32'h8, RESP_OKAY);
        // Wrong code in mid-sequence aborts it
        i_cpu.bus_wr(UNLOCK_A1, UNLOCK_D1);
        i_cpu.bus_wr(UNLOCK_A2, UNLOCK_D2);
        i_cpu.bus_wr(UNLOCK_A1, 8'h77);
        i_cpu.bus_wr(16'he500, 8'h3f);
        chk("aborted", 0, n_prog);
        i_cpu.cmd(1'b1, 16'he500, 8'h3f);
        chk("unsafe", 1, vec_unsafe);
        // Busy, exec and unsafe bits while the program operation runs
        axi_rd(OFS_STATUS, 32'h19, RESP_OKAY);
        i_cpu.poll(16'he500, tog, ok, v);
        chk("toggle", 1, tog);
        chk("settled", 32'h3c, {24'h0, v});
        chk("poll done", 1, ok);
        chk("prog count", 1, n_prog);
        chk("prog addr", 32'he500, {16'h0, arr_addr});
        chk("prog data", 32'h3f, {24'h0, arr_wdata});
        axi_wr(OFS_MAPCOMMIT, 32'h55, RESP_OKAY);
        chk("map bad key", 0, ram_code_map);
        axi_wr(OFS_MAPCOMMIT, {24'h0, KEY_MAP}, RESP_OKAY);
        chk("map", 3, {ram_code_map, vectors_in_ram});
        // Byte lane 0 off: the staged map must not move
        wstrb <= 4'he;
        axi_wr(OFS_MAP, 32'h0, RESP_OKAY);
        wstrb <= 4'hf;
        axi_rd(OFS_MAP, 32'h6, RESP_OKAY);
        // Clock enable low freezes the decoder, so no program starts
        ce <= 1'b0;
        i_cpu.cmd(1'b1, 16'he500, 8'h3f);
        ce <= 1'b1;
        chk("frozen", 1, n_prog);
        i_cpu.cmd(1'b0, 16'he000, 8'h00);
        chk("safe", 0, vec_unsafe);
        i_cpu.poll(16'he000, tog, ok, v);
        chk("erase done", 1, ok);
        chk("erase count", 1, n_erase);
        chk("erase addr", 32'he000, {16'h0, arr_addr});
        chk("fl_rvalid", 0, i_cpu.rv_bad);
        axi_wr(OFS_MODE, {24'h0, MODE_RST}, RESP_OKAY);
        axi_wr(OFS_COMMIT, {24'h0, KEY_MODE}, RESP_OKAY);
        chk("window off", 0, {30'h0, flash_window_select});
        chk("bank off", 0, array_bank_choice);
        axi_rd(OFS_STATUS, 32'h6, RESP_OKAY);
        i_cpu.cmd(1'b1, 16'he500, 8'h3f);
        chk("prog disabled", 1, n_prog);
        axi_wr(OFS_MAP, 32'h0, RESP_OKAY);
        axi_wr(OFS_MAPCOMMIT, {24'h0, KEY_MAP}, RESP_OKAY);
        chk("unmap", 0, {ram_code_map, vectors_in_ram});
        axi_wr(OFS_CLK, 32'h11, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("no clk reset", 0, n_rst);
        axi_wr(OFS_CLK, {24'h0, CLK_RST_VAL}, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("clk reset", 1, n_rst);
        complete_run;
    end
endmodule : fepc_flash_ctrl_tb

/* src/fepc_cmd_if.sv */
// Interface: CPU flash writes toward the sequence decoder and its commands
`timescale 1ns/100ps
interface fepc_cmd_if;
    logic        en;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        erase;
    logic        prog;
    logic [15:0] op_addr;
    logic [7:0]  op_data;
    modport src (output en, wr, addr, data,
                 input  erase, prog, op_addr, op_data);
    modport dec (input  en, wr, addr, data,
                 output erase, prog, op_addr, op_data);
endinterface : fepc_cmd_if

/* src/fepc_flash_ctrl.sv */
// Top: flash erase and program control with AXI4-Lite registers
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
module fepc_flash_ctrl #(
    parameter int ERASE_CYCLES = fepc_pkg::ERASE_CYC,
    parameter int PROG_CYCLES  = fepc_pkg::PROG_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        fl_wr,
    input  wire logic        fl_rd,
    input  wire logic [15:0] fl_addr,
    input  wire logic [7:0]  fl_wdata,
    output logic [7:0]       fl_rdata,
    output logic             fl_rvalid,
    input  wire logic [7:0]  arr_rdata,
    output logic             arr_erase,
    output logic             arr_prog,
    output logic [15:0]      arr_addr,
    output logic [7:0]       arr_wdata,
    output logic [1:0]       flash_window_select,
    output logic             array_bank_choice,
    output logic             ram_code_map,
    output logic             vectors_in_ram,
    output logic             sys_clk_reset,
    output logic             vec_unsafe
);
    import fepc_pkg::*;

    fepc_cmd_if cif ();

    logic [7:0]  mode_pend, mode_act, map_pend;
    logic [7:0]  next_mode_pend, next_mode_act, next_map_pend;
    logic        next_ram_code_map, next_vectors_in_ram, next_sys_clk_reset;
    logic        next_awready, next_wready, next_bvalid;
    logic        next_arready, next_rvalid;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata, rd_word;
    logic        wr_fire, rd_fire, wr_hit, rd_hit, exec_en;
    logic        busy, next_busy, toggle, next_toggle;
    logic [31:0] cnt, next_cnt;
    logic [7:0]  next_fl_rdata, wbyte;
    logic        next_fl_rvalid, next_arr_erase, next_arr_prog;
    logic        next_vec_unsafe;
    logic [15:0] next_arr_addr;
    logic [7:0]  next_arr_wdata;

    // Both channels are raised together, so one handshake edge covers both
    assign wr_fire = awvalid && awready && wvalid && wready && ce;
    assign rd_fire = arvalid && arready && ce;
    assign wbyte   = wdata[7:0];
    assign exec_en = mode_act[EXEC_LSB +: 3] == EXEC_ON;
    assign wr_hit  = awaddr == OFS_MODE || awaddr == OFS_COMMIT ||
                     awaddr == OFS_MAP || awaddr == OFS_MAPCOMMIT ||
                     awaddr == OFS_CLK;
    // Read decode must follow araddr, not the last write address
    assign rd_hit  = araddr == OFS_MODE || araddr == OFS_COMMIT ||
                     araddr == OFS_MAP || araddr == OFS_MAPCOMMIT ||
                     araddr == OFS_CLK || araddr == OFS_STATUS;

    // Decoder is held idle while disabled or an operation runs
    assign cif.en   = exec_en && !busy;
    assign cif.wr   = fl_wr;
    assign cif.addr = fl_addr;
    assign cif.data = fl_wdata;

    fepc_seq_decode u_dec (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .cif     (cif)
    );

    // Read mux; commit and clock registers are write-only and read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (araddr)
            OFS_MODE:   rd_word[7:0] = mode_pend;
            OFS_MAP:    rd_word[7:0] = map_pend;
            OFS_STATUS: begin
                rd_word[STAT_BUSY]   = busy;
                rd_word[STAT_VEC]    = vectors_in_ram;
                rd_word[STAT_RAM]    = ram_code_map;
                rd_word[STAT_EXEC]   = exec_en;
                rd_word[STAT_UNSAFE] = vec_unsafe;
            end
            default:    rd_word = 32'h0000_0000;
        endcase
    end

    // AXI4-Lite channel control, one write and one read at a time
    always_comb begin
        next_awready = 1'b0;
        next_wready  = 1'b0;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_arready = 1'b0;
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        if (bvalid && bready) next_bvalid = 1'b0;
        if (awvalid && wvalid && !awready && !bvalid) begin
            next_awready = 1'b1;
            next_wready  = 1'b1;
        end
        if (wr_fire) begin
            next_bvalid = 1'b1;
            next_bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid && rready) next_rvalid = 1'b0;
        if (arvalid && !arready && !rvalid) next_arready = 1'b1;
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rdata  = rd_word;
            next_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else if (ce) begin
            awready <= next_awready;
            wready  <= next_wready;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    // Staged mode and map values; only the exact key moves them live
    always_comb begin
        next_mode_pend      = mode_pend;
        next_mode_act       = mode_act;
        next_map_pend       = map_pend;
        next_ram_code_map   = ram_code_map;
        next_vectors_in_ram = vectors_in_ram;
        next_sys_clk_reset  = 1'b0;
        if (wr_fire && wstrb[0]) begin
            case (awaddr)
                OFS_MODE:   next_mode_pend = wbyte;
                OFS_COMMIT: begin
                    if (wbyte == KEY_MODE) next_mode_act = mode_pend;
                end // Other values ignored
                OFS_MAP:    next_map_pend = wbyte;
                OFS_MAPCOMMIT: begin
                    if (wbyte == KEY_MAP) begin
                        next_ram_code_map   = map_pend[RAMCODE_BIT];
                        next_vectors_in_ram = map_pend[VECRAM_BIT];
                    end
                end
                OFS_CLK:    next_sys_clk_reset = wbyte == CLK_RST_VAL;
                default:    next_mode_pend = mode_pend;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_pend      <= MODE_RST;
            mode_act       <= MODE_RST;
            map_pend       <= MAP_RST;
            ram_code_map   <= 1'b0;
            vectors_in_ram <= 1'b0;
            sys_clk_reset  <= 1'b0;
        end else if (ce) begin
            mode_pend      <= next_mode_pend;
            mode_act       <= next_mode_act;
            map_pend       <= next_map_pend;
            ram_code_map   <= next_ram_code_map;
            vectors_in_ram <= next_vectors_in_ram;
            sys_clk_reset  <= next_sys_clk_reset;
        end
    end
    // Window and bank follow the committed mode; 00 is the initial mapping
    assign flash_window_select = mode_act[WIN_LSB +: 2];
    assign array_bank_choice   = mode_act[BANK_BIT];

    // Array operation timer and toggle read; timer bounds the busy window
    always_comb begin
        next_busy       = busy;
        next_cnt        = cnt;
        next_toggle     = toggle;
        next_arr_erase  = cif.erase;
        next_arr_prog   = cif.prog;
        next_arr_addr   = arr_addr;
        next_arr_wdata  = arr_wdata;
        next_fl_rvalid  = fl_rd;
        next_fl_rdata   = fl_rdata;
        next_vec_unsafe = busy && !vectors_in_ram;
        if (busy) begin
            if (cnt == 32'h0000_0000) next_busy = 1'b0;
            else next_cnt = cnt - 32'h0000_0001;
        end
        if (cif.erase || cif.prog) begin
            next_busy      = 1'b1;
            next_cnt       = cif.erase ? 32'(ERASE_CYCLES - 1)
                                       : 32'(PROG_CYCLES - 1);
            next_arr_addr  = cif.op_addr;
            next_arr_wdata = cif.op_data;
        end
        if (fl_rd) begin
            next_fl_rdata = arr_rdata;
            if (busy) begin
                next_fl_rdata[TOGGLE_BIT] = toggle;
                next_toggle = !toggle;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy       <= 1'b0;
            cnt        <= 32'h0000_0000;
            toggle     <= 1'b0;
            arr_erase  <= 1'b0;
            arr_prog   <= 1'b0;
            arr_addr   <= 16'h0000;
            arr_wdata  <= 8'h00;
            fl_rvalid  <= 1'b0;
            fl_rdata   <= 8'h00;
            vec_unsafe <= 1'b0;
        end else if (ce) begin
            busy       <= next_busy;
            cnt        <= next_cnt;
            toggle     <= next_toggle;
            arr_erase  <= next_arr_erase;
            arr_prog   <= next_arr_prog;
            arr_addr   <= next_arr_addr;
            arr_wdata  <= next_arr_wdata;
            fl_rvalid  <= next_fl_rvalid;
            fl_rdata   <= next_fl_rdata;
            vec_unsafe <= next_vec_unsafe;
        end
    end

    // Checks on committed state, sequences and reads
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    mode_commit_a: assert property (
        wr_fire && wstrb[0] && awaddr == OFS_COMMIT && wbyte == KEY_MODE
        |=> mode_act == $past(mode_pend)) else $error("mode not committed");
    bad_key_a: assert property (
        wr_fire && awaddr == OFS_COMMIT && wbyte != KEY_MODE
        |=> $stable(mode_act)) else $error("mode moved without key");
    exec_enable_a: assert property (
        wr_fire && wstrb[0] && awaddr == OFS_COMMIT && wbyte == KEY_MODE
        && mode_pend[EXEC_LSB +: 3] == EXEC_ON |=> cif.en || busy)
        else $error("execution not enabled");
    exec_disable_a: assert property (
        wr_fire && wstrb[0] && awaddr == OFS_COMMIT && wbyte == KEY_MODE
        && mode_pend == {EXEC_OFF, WIN_INIT, mode_pend[2:0]}
        |=> !exec_en && flash_window_select == WIN_INIT)
        else $error("execution not disabled");
    ignore_off_a: assert property (
        !exec_en ##1 !exec_en |=> !arr_erase && !arr_prog)
        else $error("command while disabled");
    toggle_read_a: assert property (
        fl_rd && busy && ce |=> fl_rvalid
        && fl_rdata[TOGGLE_BIT] == $past(toggle) && toggle != $past(toggle))
        else $error("no toggle while busy");
    stable_read_a: assert property (
        fl_rd && !busy && ce |=> fl_rdata == $past(arr_rdata))
        else $error("idle read not stable");
    map_commit_a: assert property (
        wr_fire && wstrb[0] && awaddr == OFS_MAPCOMMIT && wbyte == KEY_MAP
        |=> ram_code_map == $past(map_pend[RAMCODE_BIT])
        && vectors_in_ram == $past(map_pend[VECRAM_BIT]))
        else $error("map not committed");
    clk_reset_a: assert property (
        wr_fire && wstrb[0] && awaddr == OFS_CLK && wbyte == CLK_RST_VAL
        |=> sys_clk_reset) else $error("no clock reset");
    prog_start_a: assert property (
        cif.prog && ce |=> arr_prog && busy
        && arr_wdata == $past(cif.op_data)) else $error("program not issued");
    vec_flag_a: assert property (
        busy && !vectors_in_ram && ce |=> vec_unsafe)
        else $error("unsafe vectors not flagged");

    erase_seen_c: cover property (arr_erase);
    prog_seen_c: cover property (arr_prog);
    map_ram_c: cover property (ram_code_map && vectors_in_ram);
    clk_rst_c: cover property (sys_clk_reset);
endmodule : fepc_flash_ctrl

/* src/fepc_pkg.sv */
// Package: register map, keys, command codes and timing for flash control
package fepc_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] OFS_MODE      = 8'h00;
    localparam logic [7:0] OFS_COMMIT    = 8'h04;
    localparam logic [7:0] OFS_MAP       = 8'h08;
    localparam logic [7:0] OFS_MAPCOMMIT = 8'h0c;
    localparam logic [7:0] OFS_CLK       = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;
    // Keys and trigger values
    localparam logic [7:0] KEY_MODE      = 8'hd5;
    localparam logic [7:0] KEY_MAP       = 8'hd4;
    localparam logic [7:0] CLK_RST_VAL   = 8'h10;
    // Field layout of flash_mode_control and system_map_control
    localparam int         EXEC_LSB      = 5;
    localparam int         WIN_LSB       = 3;
    localparam int         BANK_BIT      = 2;
    localparam int         RAMCODE_BIT   = 2;
    localparam int         VECRAM_BIT    = 1;
    localparam logic [2:0] EXEC_ON       = 3'b101;
    localparam logic [2:0] EXEC_OFF      = 3'b010;
    localparam logic [1:0] WIN_INIT      = 2'b00;
    localparam logic [7:0] MODE_RST      = 8'h40;
    localparam logic [7:0] MAP_RST       = 8'h00;
    // Status register bits
    localparam int         STAT_BUSY     = 0;
    localparam int         STAT_VEC      = 1;
    localparam int         STAT_RAM      = 2;
    localparam int         STAT_EXEC     = 3;
    localparam int         STAT_UNSAFE   = 4;
    // Command sequence addresses and codes
    localparam logic [15:0] UNLOCK_A1    = 16'hf555;
    localparam logic [15:0] UNLOCK_A2    = 16'hfaaa;
    localparam logic [7:0]  UNLOCK_D1    = 8'haa;
    localparam logic [7:0]  UNLOCK_D2    = 8'h55;
    localparam logic [7:0]  CMD_ERASE    = 8'h80;
    localparam logic [7:0]  CMD_SECTOR   = 8'h30;
    localparam logic [7:0]  CMD_PROG     = 8'ha0;
    localparam int          TOGGLE_BIT   = 6;
    // Array operation lengths in clock cycles; AXI response codes
    localparam int          ERASE_CYC    = 20000;
    localparam int          PROG_CYC     = 100;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;
    // Command sequence decoder states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_U1   = 3'b001,
        SEQ_U2   = 3'b010,
        SEQ_ERA  = 3'b011,
        SEQ_E1   = 3'b100,
        SEQ_E2   = 3'b101,
        SEQ_PRG  = 3'b110
    } fepc_seq_t;
endpackage : fepc_pkg

/* src/fepc_seq_decode.sv */
// Module: decoder of unlock, erase and program bus write sequences
`timescale 1ns/100ps
module fepc_seq_decode (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    fepc_cmd_if.dec  cif
);
    import fepc_pkg::*;

    fepc_seq_t   state;
    fepc_seq_t   next_state;
    logic        next_erase;
    logic        next_prog;
    logic [15:0] next_addr;
    logic [7:0]  next_data;
    logic        unl1;
    logic        unl2;

    // Unlock writes carry the low byte of the other unlock address
    assign unl1 = cif.addr == UNLOCK_A1 && cif.data == UNLOCK_D1;
    assign unl2 = cif.addr == UNLOCK_A2 && cif.data == UNLOCK_D2;

    // Sequence walk; any stray write falls back to idle
    always_comb begin
        next_state = state;
        next_erase = 1'b0;
        next_prog  = 1'b0;
        next_addr  = cif.op_addr;
        next_data  = cif.op_data;
        if (!cif.en) begin
            next_state = SEQ_IDLE;
        end else if (cif.wr) begin
            case (state)
                SEQ_IDLE: next_state = unl1 ? SEQ_U1 : SEQ_IDLE;
                SEQ_U1:   next_state = unl2 ? SEQ_U2 : SEQ_IDLE;
                SEQ_U2: begin
                    next_state = SEQ_IDLE;
                    if (cif.addr == UNLOCK_A1 && cif.data == CMD_ERASE) begin
                        next_state = SEQ_ERA;
                    end else if (cif.addr == UNLOCK_A1 &&
                                 cif.data == CMD_PROG) begin
                        next_state = SEQ_PRG;
                    end
                end
                SEQ_ERA:  next_state = unl1 ? SEQ_E1 : SEQ_IDLE;
                SEQ_E1:   next_state = unl2 ? SEQ_E2 : SEQ_IDLE;
                SEQ_E2: begin
                    next_state = SEQ_IDLE;
                    if (cif.data == CMD_SECTOR) begin
                        next_erase = 1'b1;
                        next_addr  = cif.addr;
                    end
                end
                SEQ_PRG: begin
                    next_state = SEQ_IDLE;
                    next_prog  = 1'b1;
                    next_addr  = cif.addr;
                    next_data  = cif.data;
                end
                default:  next_state = SEQ_IDLE;
            endcase
        end
    end

    // Registers of the decoder
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state       <= SEQ_IDLE;
            cif.erase   <= 1'b0;
            cif.prog    <= 1'b0;
            cif.op_addr <= 16'h0000;
            cif.op_data <= 8'h00;
        end else if (ce) begin
            state       <= next_state;
            cif.erase   <= next_erase;
            cif.prog    <= next_prog;
            cif.op_addr <= next_addr;
            cif.op_data <= next_data;
        end
    end
endmodule : fepc_seq_decode
